// ==== src/sideband_defs.svh ====
/*
 * Constants of the module sideband control and status block: register
 * offsets, field positions, reset values and timing counts.
 * Assumes a 40 MHz aclk; every count below is derived from that rate.
 */
`ifndef SIDEBAND_DEFS_SVH
`define SIDEBAND_DEFS_SVH

// Clock rate and derived per-unit cycle counts
`define CLK_HZ            40000000
`define CYC_PER_MS        (`CLK_HZ / 1000)
`define CYC_PER_US        (`CLK_HZ / 1000000)

// Timing figures in their own units
`define T_INIT_MS         2000
`define T_RESET_MIN_US    2
`define T_PDOWN_OFF_MS    300

// Timing counts in cycles
`define INIT_CYC          (`CYC_PER_MS * `T_INIT_MS)
`define RESET_MIN_CYC     (`CYC_PER_US * `T_RESET_MIN_US)
`define PDOWN_OFF_CYC     (`CYC_PER_MS * `T_PDOWN_OFF_MS)

// Register byte offsets
`define REG_STATUS        8'h00
`define REG_FLAGS         8'h04
`define REG_MASK          8'h08
`define REG_CONTROL       8'h0C

// Status field positions
`define ST_NOT_READY      0
`define ST_LOW_POWER      1
`define ST_SERIAL_EN      2
`define ST_ATTENTION      3
`define ST_TXN_LSB        8
`define ST_ADDR_LSB       24

// Flag bit 0 is the monitor-data-ready event, 8:1 the conditions
`define FLAG_READY_BIT    0
`define NUM_COND          8
`define NUM_FLAGS         9
`define CTRL_PDOWN_BIT    0

// Management bus device address, reported in status
`define MGMT_DEV_ADDR     8'hA0

// Reset values and AXI response codes
`define FLAGS_RST         9'h000
`define MASK_RST          9'h000
`define PINS_RST          13'h001B
`define AXI_OKAY          2'b00
`define AXI_SLVERR        2'b10

`endif

// ==== src/sideband_pkg.sv ====
/*
 * Types of the module sideband control and status block.
 * Assumes sideband_defs.svh supplies the widths.
 */
`include "sideband_defs.svh"

package sideband_pkg;

	// Synchronised pin group: bit order fixed by the index names below
	localparam int PIN_W   = 13;
	localparam int P_RST   = 0;
	localparam int P_SEL   = 1;
	localparam int P_LPM   = 2;
	localparam int P_SCL   = 3;
	localparam int P_SDA   = 4;
	localparam int P_COND  = 5;

	typedef logic [PIN_W-1:0]       pins_t;
	typedef logic [`NUM_FLAGS-1:0]  flags_t;

	// AXI4-Lite slave side state
	typedef struct packed {
		logic        aw_held;
		logic [7:0]  aw_addr;
		logic        w_held;
		logic [31:0] w_data;
		logic [3:0]  w_strb;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} axi_s;

	// Whole block state
	typedef struct packed {
		pins_t       s1;
		pins_t       s2;
		pins_t       s3;
		pins_t       pin;
		logic [7:0]  rst_cnt;
		logic        in_mreset;
		logic [26:0] init_cnt;
		logic        ready;
		logic        serial_up;
		logic        pdown;
		flags_t      mask;
		flags_t      flags;
		logic        stop_armed;
		logic [7:0]  txn_cnt;
		logic        attn_n;
		logic        low_power;
		logic        serial_en;
		axi_s        axi;
	} state_s;

endpackage : sideband_pkg

// ==== src/module_sideband_control_status.sv ====
/*
 * Management-side control and status logic of a pluggable transceiver
 * module: pin sampling, reset pulse filter, initialisation timer,
 * sticky condition flags with masks, clear-on-read, attention output,
 * low-power control and a register file on AXI4-Lite.
 * Assumes aclk at 40 MHz; all pins are asynchronous to it; the 2-wire
 * clock is only sampled, never used as a clock.
 */
// Our own choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/10ps
`default_nettype none

module module_sideband_control_status
	import sideband_pkg::*;
#(
	parameter int unsigned INIT_CYC      = `INIT_CYC,
	parameter int unsigned PDOWN_OFF_CYC = `PDOWN_OFF_CYC
) (
	// Clock and reset
	input  wire logic                 aclk,
	input  wire logic                 aresetn,
	// AXI4-Lite write address
	input  wire logic                 s_axi_awvalid,
	output logic                      s_axi_awready,
	input  wire logic [7:0]           s_axi_awaddr,
	// AXI4-Lite write data
	input  wire logic                 s_axi_wvalid,
	output logic                      s_axi_wready,
	input  wire logic [31:0]          s_axi_wdata,
	input  wire logic [3:0]           s_axi_wstrb,
	// AXI4-Lite write response
	output logic                      s_axi_bvalid,
	input  wire logic                 s_axi_bready,
	output logic [1:0]                s_axi_bresp,
	// AXI4-Lite read address
	input  wire logic                 s_axi_arvalid,
	output logic                      s_axi_arready,
	input  wire logic [7:0]           s_axi_araddr,
	// AXI4-Lite read data
	output logic                      s_axi_rvalid,
	input  wire logic                 s_axi_rready,
	output logic [31:0]               s_axi_rdata,
	output logic [1:0]                s_axi_rresp,
	// Sideband pins from the host
	input  wire logic                 module_reset_n,
	input  wire logic                 module_select_n,
	input  wire logic                 low_power_request,
	input  wire logic                 scl_in,
	input  wire logic                 sda_in,
	// Monitored conditions, bit 0 is receive loss-of-signal
	input  wire logic [`NUM_COND-1:0] condition_in,
	// Sideband pins to the host
	output logic                      attention_out_n,
	output logic                      module_present_n,
	// Internal controls
	output logic                      low_power_active,
	output logic                      serial_respond_en
);

	////////////////////////////////////////////////////////////////////
	// Declarations

	state_s q;              // Registered state
	state_s d;              // Next state
	pins_t  pins_raw;       // Raw pin group
	pins_t  pin_new;        // Filtered pins before registering
	flags_t cond_rise;      // Condition onsets, flag 0 never from a pin
	logic   aw_take;        // Write address handshake
	logic   w_take;         // Write data handshake
	logic   ar_take;        // Read address handshake
	logic   wr_do;          // Both halves of a write are held
	logic   scl_fall;       // Filtered 2-wire clock falling edge
	logic   stop_seen;      // Data rising while clock high
	logic   flag_read;      // Flags register read accepted
	logic   restart;        // Start of an initialisation period
	logic   pin_reset;      // Filtered reset pin active
	logic [31:0] rd_word;   // Read mux
	logic [1:0]  rd_resp;   // Read response code

	assign pins_raw = {condition_in, sda_in, scl_in, low_power_request,
		module_select_n, module_reset_n};

	// Handshake outputs: one transaction of each kind in flight
	assign s_axi_awready = !q.axi.aw_held && !q.axi.bvalid;
	assign s_axi_wready  = !q.axi.w_held && !q.axi.bvalid;
	assign s_axi_arready = !q.axi.rvalid;
	assign aw_take = s_axi_awvalid && s_axi_awready;
	assign w_take  = s_axi_wvalid && s_axi_wready;
	assign ar_take = s_axi_arvalid && s_axi_arready;
	assign wr_do   = q.axi.aw_held && q.axi.w_held;
	assign flag_read = ar_take && (s_axi_araddr == `REG_FLAGS);

	// Edges on filtered pins
	// Filter kept apart from d so edges never feed back through it
	assign pin_new = (q.s2 & ~(q.s2 ^ q.s3)) | (q.pin & (q.s2 ^ q.s3));
	assign scl_fall  = q.pin[P_SCL] && !pin_new[P_SCL];
	assign stop_seen = q.pin[P_SCL] && pin_new[P_SCL] && !q.pin[P_SDA]
		&& pin_new[P_SDA];
	assign cond_rise = {pin_new[PIN_W-1:P_COND] & ~q.pin[PIN_W-1:P_COND],
		1'b0};

	// Outputs from flip-flops, module_present_n tied low
	assign attention_out_n   = q.attn_n;
	assign module_present_n  = 1'b0;
	assign low_power_active  = q.low_power;
	assign serial_respond_en = q.serial_en;
	assign s_axi_bvalid = q.axi.bvalid;
	assign s_axi_bresp  = q.axi.bresp;
	assign s_axi_rvalid = q.axi.rvalid;
	assign s_axi_rdata  = q.axi.rdata;
	assign s_axi_rresp  = q.axi.rresp;

	////////////////////////////////////////////////////////////////////
	// Read mux

	// Unmapped offsets answer SLVERR with zero data
	always_comb begin
		rd_word = 32'h0000_0000;
		rd_resp = `AXI_OKAY;
		case (s_axi_araddr)
			`REG_STATUS: begin
				rd_word[`ST_NOT_READY] = !q.ready;
				rd_word[`ST_LOW_POWER] = q.low_power;
				rd_word[`ST_SERIAL_EN] = q.serial_en;
				rd_word[`ST_ATTENTION] = !q.attn_n;
				rd_word[`ST_TXN_LSB +: 8] = q.txn_cnt;
				rd_word[`ST_ADDR_LSB +: 8] = `MGMT_DEV_ADDR;
			end
			`REG_FLAGS:   rd_word[`NUM_FLAGS-1:0] = q.flags;
			`REG_MASK:    rd_word[`NUM_FLAGS-1:0] = q.mask;
			`REG_CONTROL: rd_word[`CTRL_PDOWN_BIT] = q.pdown;
			default:      rd_resp = `AXI_SLVERR;
		endcase
	end

	////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		d = q;
		// Three-stage pin sampling; a bit moves once stages 2 and 3 agree
		d.s1 = pins_raw;
		d.s2 = q.s1;
		d.s3 = q.s2;
		d.pin = pin_new;

		// Reset pin filter: short glitches below the minimum are ignored
		if (d.pin[P_RST]) begin
			d.rst_cnt = 8'h00;
		end else if (q.rst_cnt != 8'(`RESET_MIN_CYC)) begin
			d.rst_cnt = q.rst_cnt + 8'h01;
		end
		d.in_mreset = (d.rst_cnt == 8'(`RESET_MIN_CYC))
			|| (q.in_mreset && !d.pin[P_RST]);
		pin_reset = d.in_mreset;

		// 2-wire stop followed by a clock fall marks a finished transfer
		if (stop_seen) begin
			d.stop_armed = 1'b1;
		end else if (scl_fall && q.stop_armed) begin
			d.stop_armed = 1'b0;
			d.txn_cnt = q.txn_cnt + 8'h01;
		end

		// AXI write channel capture in either order
		if (aw_take) begin
			d.axi.aw_held = 1'b1;
			d.axi.aw_addr = s_axi_awaddr;
		end
		if (w_take) begin
			d.axi.w_held = 1'b1;
			d.axi.w_data = s_axi_wdata;
			d.axi.w_strb = s_axi_wstrb;
		end
		if (q.axi.bvalid && s_axi_bready) begin
			d.axi.bvalid = 1'b0;
		end

		// Writes take effect at once, well inside any deadline measured
		// from the end of the transfer
		if (wr_do) begin
			d.axi.aw_held = 1'b0;
			d.axi.w_held = 1'b0;
			d.axi.bvalid = 1'b1;
			d.axi.bresp = `AXI_OKAY;
			case (q.axi.aw_addr)
				`REG_MASK: begin
					if (q.axi.w_strb[0]) begin
						d.mask[7:0] = q.axi.w_data[7:0];
					end
					if (q.axi.w_strb[1]) begin
						d.mask[8] = q.axi.w_data[8];
					end
				end
				`REG_CONTROL: begin
					if (q.axi.w_strb[0]) begin
						d.pdown = q.axi.w_data[`CTRL_PDOWN_BIT];
					end
				end
				`REG_STATUS, `REG_FLAGS: begin
					// Read-only, write ignored
				end
				default: d.axi.bresp = `AXI_SLVERR;
			endcase
		end

		// AXI read channel; data registered on the address handshake
		if (ar_take) begin
			d.axi.rvalid = 1'b1;
			d.axi.rdata = rd_word;
			d.axi.rresp = rd_resp;
		end else if (q.axi.rvalid && s_axi_rready) begin
			d.axi.rvalid = 1'b0;
		end

		// Flags: clear-on-read, but a new onset in the same cycle wins
		if (flag_read) begin
			d.flags = `FLAGS_RST;
		end
		d.flags = d.flags | cond_rise;

		// Initialisation timer: restarted by reset or power-down release
		restart = pin_reset || (q.pdown && !d.pdown);
		if (pin_reset || d.pdown) begin
			d.ready = 1'b0;
		end
		if (pin_reset) begin
			d.serial_up = 1'b0;
			d.flags = `FLAGS_RST;
			d.init_cnt = 27'(INIT_CYC);
		end else if (restart) begin
			d.init_cnt = 27'(PDOWN_OFF_CYC);
		end else if (!q.ready && !d.pdown) begin
			if (q.init_cnt <= 27'h000_0001) begin
				d.ready = 1'b1;
				d.serial_up = 1'b1;
				d.flags[`FLAG_READY_BIT] = 1'b1;
			end else begin
				d.init_cnt = q.init_cnt - 27'h000_0001;
			end
		end

		// Low power from the pin or the software bit
		d.low_power = q.pin[P_LPM] || q.pdown;
		// Bus responses follow select once the bus is up
		d.serial_en = q.serial_up && !q.pin[P_SEL]
			&& !q.in_mreset;
		// Attention held while any unmasked flag remains
		d.attn_n = ~|(q.flags & ~q.mask);
	end

	////////////////////////////////////////////////////////////////////
	// State register

	// Synchronous reset loads constants only
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q <= '0;
			q.s1 <= `PINS_RST;
			q.s2 <= `PINS_RST;
			q.s3 <= `PINS_RST;
			q.pin <= `PINS_RST;
			q.init_cnt <= 27'(INIT_CYC);
			q.mask <= `MASK_RST;
			q.flags <= `FLAGS_RST;
			q.attn_n <= 1'b1;
		end else begin
			q <= d;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Assertions

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_write_pair;
		q.axi.aw_held && q.axi.w_held;
	endsequence

	sequence s_resp_up;
		q.axi.bvalid;
	endsequence

	sequence s_unmasked_flag;
		|(q.flags & ~q.mask);
	endsequence

	// Ready event logged, then attention unless that event is masked
	sequence s_ready_then_attn;
		q.ready && q.flags[`FLAG_READY_BIT] ##1
		(!attention_out_n || q.mask[`FLAG_READY_BIT]);
	endsequence

	// An unmasked flag pulls attention low on the next edge
	a_attn_asserts: assert property (
		s_unmasked_flag |=> !attention_out_n)
		else $error("attention not asserted for unmasked flag");

	// No unmasked flag left: attention released on the next edge
	a_attn_release: assert property (
		!(|(q.flags & ~q.mask)) |=> attention_out_n)
		else $error("attention held with no unmasked flag");

	// Flags that are all masked keep attention released
	a_mask_inhibit: assert property (
		(q.flags == q.mask) ##1 (q.flags == q.mask)
		|-> attention_out_n)
		else $error("masked flags still drive attention");

	// An onset sets its own flag unless the module is held in reset
	a_cond_sets: assert property (
		(|cond_rise) && !pin_reset |=> |(q.flags & $past(cond_rise)))
		else $error("condition onset did not set its flag");

	// A flags read with no competing set leaves every flag clear
	a_read_clears: assert property (
		flag_read && !(|cond_rise) && (q.ready || q.init_cnt > 27'h2)
		|=> q.flags == `FLAGS_RST)
		else $error("flag read did not clear flags");

	// Last timer count logs the ready event; a reload does not
	a_init_ready: assert property (
		!q.ready && !d.pdown && !restart && q.init_cnt == 27'h1
		|=> s_ready_then_attn)
		else $error("ready event missing after init count");

	// Either low-power source reaches the output on the next edge
	a_low_power: assert property (
		(q.pin[P_LPM] || q.pdown) |=> low_power_active)
		else $error("low power not entered");

	// Deselected: the bus is not answered
	a_select_off: assert property (
		q.pin[P_SEL] |=> !serial_respond_en)
		else $error("bus enabled while deselected");

	// Selected, bus up and no module reset: the bus is answered
	a_select_on: assert property (
		!q.pin[P_SEL] && q.serial_up && !q.in_mreset
		|=> serial_respond_en)
		else $error("bus not enabled while selected");

	// A low level that reaches the minimum becomes a module reset
	a_reset_filter: assert property (
		!d.pin[P_RST] && q.rst_cnt == 8'(`RESET_MIN_CYC - 1)
		|=> q.in_mreset ##1 !q.ready)
		else $error("long reset pulse not honoured");

	// A module reset clears the flags and takes the bus down
	a_reset_clears: assert property (
		pin_reset |=> (q.flags == `FLAGS_RST) && !q.ready
		&& !q.serial_up)
		else $error("module reset left state behind");

	// A stop followed by a clock fall counts one finished transfer
	a_txn_count: assert property (
		scl_fall && q.stop_armed
		|=> q.txn_cnt == $past(q.txn_cnt) + 8'h01)
		else $error("finished transfer not counted");

	// Both halves held produce a response on the next edge
	a_write_answer: assert property (
		s_write_pair |=> s_resp_up)
		else $error("write without response");

endmodule : module_sideband_control_status

`default_nettype wire

// ==== dv/host_sideband_model.sv ====
/*
 * Host controller model for the sideband pins and the 2-wire lines.
 * Assumes the bench calls its tasks; the link clock runs only in frames.
 */
`timescale 1ns/10ps
`default_nettype none

module host_sideband_model (
	// Clock of the bench
	input  wire logic aclk,
	// Pins toward the module
	output logic      scl,
	output logic      sda,
	output logic      reset_n,
	output logic      select_n,
	output logic      lp_req
);
	// Pulled-up lines idle high, module selected, other pins released
	initial begin
		scl      = 1'b1;
		sda      = 1'b1;
		reset_n  = 1'b1;
		select_n = 1'b0;
		lp_req   = 1'b0;
	end

	// Pins move just after a bench clock edge
	task automatic set_pins(input logic r, input logic s, input logic l);
		@(posedge aclk);
		reset_n  <= r;
		select_n <= s;
		lp_req   <= l;
	endtask : set_pins

	// One frame at a 200 ns link period, off the bench clock phase
	task automatic frame();
		#7 sda = 1'b0;
		#100;
		repeat (9) begin
			scl = 1'b0;
			#50 sda = ~sda;
			#50 scl = 1'b1;
			#100;
		end
		scl = 1'b0;
		#50 sda = 1'b0;
		#50 scl = 1'b1;
		#100 sda = 1'b1;
		#100;
	endtask : frame
endmodule : host_sideband_model

`default_nettype wire

// ==== dv/module_sideband_control_status_test.sv ====
/*
 * Self-checking bench of the sideband control and status block.
 * Assumes shortened init and power-down counts; AXI results are
 * checked by a watcher against a queue of expected answers.
 */
`timescale 1ns/10ps
`default_nettype none

module module_sideband_control_status_test;
	import sideband_pkg::*;
	localparam int INIT = 100;   // Shortened init count
	localparam int PDN  = 50;    // Shortened power-up count

	logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
	logic s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [7:0]  condition_in, rnd;
	logic scl, sda, rst_n, sel_n, lp, att_n, pres_n, lp_act, ser_en;
	logic [33:0] exp_q[$];   // Expected {resp, data} per AXI answer
	int          n_errors, checked, k;

	module_sideband_control_status #(.INIT_CYC(INIT), .PDOWN_OFF_CYC(PDN))
	u_dut (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .module_reset_n(rst_n),
		.module_select_n(sel_n), .low_power_request(lp), .scl_in(scl),
		.sda_in(sda), .condition_in(condition_in),
		.attention_out_n(att_n), .module_present_n(pres_n),
		.low_power_active(lp_act), .serial_respond_en(ser_en));

	host_sideband_model u_host (.aclk(aclk), .scl(scl), .sda(sda),
		.reset_n(rst_n), .select_n(sel_n), .lp_req(lp));

	////////////////////////////////////////////////////////////////////
	// Clock, 25 ns period
	initial begin
		aclk = 1'b0;
		forever #12.5 aclk = ~aclk;
	end

	// Counted compare, reported at once on a mismatch
	task automatic chk(input logic [33:0] got, input logic [33:0] exp);
		checked++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// Watcher: each AXI answer takes the oldest expectation
	always @(negedge aclk) begin
		if (s_axi_rvalid && s_axi_rready)
			chk({s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
		if (s_axi_bvalid && s_axi_bready)
			chk({s_axi_bresp, 32'h0000_0000}, exp_q.pop_front());
	end

	// One AXI access; handshakes judged on values settled before the edge
	task automatic xfer(input bit wr, input logic [7:0] a,
			input logic [31:0] d, input logic [33:0] e);
		int  n;
		logic aw, w, ar, r, b;
		exp_q.push_back(e);
		@(posedge aclk);
		if (wr) begin
			s_axi_awaddr  <= a;
			s_axi_wdata   <= d;
			s_axi_awvalid <= 1'b1;
			s_axi_wvalid  <= 1'b1;
			s_axi_bready  <= 1'b1;
		end else begin
			s_axi_araddr  <= a;
			s_axi_arvalid <= 1'b1;
			s_axi_rready  <= 1'b1;
		end
		for (n = 0; n < 60; n++) begin
			@(negedge aclk);
			aw = s_axi_awvalid && s_axi_awready;
			w  = s_axi_wvalid && s_axi_wready;
			ar = s_axi_arvalid && s_axi_arready;
			r  = s_axi_rvalid && s_axi_rready;
			b  = s_axi_bvalid && s_axi_bready;
			if (!(s_axi_awvalid || s_axi_wvalid || s_axi_bready ||
					s_axi_arvalid || s_axi_rready))
				break;
			@(posedge aclk);
			if (aw) s_axi_awvalid <= 1'b0;
			if (w) s_axi_wvalid <= 1'b0;
			if (ar) s_axi_arvalid <= 1'b0;
			if (r) s_axi_rready <= 1'b0;
			if (b) s_axi_bready <= 1'b0;
		end
		// A stuck access counts as a mismatch
		if (n == 60) report_and_stop(1);
	endtask : xfer

	// Selected pin: 0 attention, 1 low power, 2 serial enable
	function automatic logic pin(input int s);
		return (s == 0) ? att_n : (s == 1) ? lp_act : ser_en;
	endfunction : pin

	// Bounded wait for a pin level, then compare
	task automatic wait_for(input int s, input logic v, input int n);
		int i;
		for (i = 0; i < n && pin(s) !== v; i++) @(negedge aclk);
		chk({33'h0, pin(s)}, {33'h0, v});
		// A level that never comes ends the run
		if (pin(s) !== v) report_and_stop(0);
	endtask : wait_for

	// Next pseudo-random byte
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction : lfsr

	// Verdict and end of run
	task automatic report_and_stop(input int extra);
		n_errors += extra;
		$display("checks %0d mismatches %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : report_and_stop

	////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
		{s_axi_arvalid, s_axi_rready} = 2'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
		s_axi_wstrb  = 4'hF;
		condition_in = 8'h00;
		rnd          = 8'h41;
		aresetn      = 1'b0;
		n_errors     = 0;
		checked      = 0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		@(negedge aclk);
		chk({att_n, lp_act, ser_en, pres_n}, 34'h8);
		wait_for(0, 1'b0, INIT + 40);
		xfer(0, 8'h00, 0, 34'h0_A000_000C);
		xfer(0, 8'h04, 0, 34'h0_0000_0001);
		wait_for(0, 1'b1, 10);
		$display("test init done");
		// Every condition sets its own flag and raises attention
		for (int i = 0; i < 8; i++) begin
			@(posedge aclk) condition_in <= 8'h01 << i;
			wait_for(0, 1'b0, 20);
			xfer(0, 8'h04, 0, 34'h2 << i);
			wait_for(0, 1'b1, 10);
			@(posedge aclk) condition_in <= 8'h00;
		end
		$display("test conditions done");
		// Random condition held back by its mask, then let through
		rnd = lfsr(rnd);
		k   = rnd[2:0];
		xfer(1, 8'h08, 32'h2 << k, 34'h0);
		@(posedge aclk) condition_in <= 8'h01 << k;
		repeat (20) @(negedge aclk);
		chk({33'h0, att_n}, 34'h1);
		xfer(0, 8'h08, 0, 34'h2 << k);
		xfer(1, 8'h08, 0, 34'h0);
		wait_for(0, 1'b0, 10);
		xfer(0, 8'h04, 0, 34'h2 << k);
		wait_for(0, 1'b1, 10);
		@(posedge aclk) condition_in <= 8'h00;
		$display("test mask done");
		// Low-power pin and power-down bit
		u_host.set_pins(1'b1, 1'b0, 1'b1);
		wait_for(1, 1'b1, 20);
		u_host.set_pins(1'b1, 1'b0, 1'b0);
		wait_for(1, 1'b0, 20);
		xfer(1, 8'h0C, 32'h1, 34'h0);
		wait_for(1, 1'b1, 10);
		xfer(0, 8'h0C, 0, 34'h1);
		xfer(1, 8'h0C, 32'h0, 34'h0);
		wait_for(0, 1'b0, PDN + 30);
		chk({33'h0, lp_act}, 34'h0);
		xfer(0, 8'h04, 0, 34'h1);
		wait_for(0, 1'b1, 10);
		$display("test power done");
		// Select pin, short and long reset pulses
		u_host.set_pins(1'b1, 1'b1, 1'b0);
		wait_for(2, 1'b0, 20);
		u_host.set_pins(1'b1, 1'b0, 1'b0);
		wait_for(2, 1'b1, 20);
		u_host.set_pins(1'b0, 1'b0, 1'b0);
		repeat (40) @(posedge aclk);
		u_host.set_pins(1'b1, 1'b0, 1'b0);
		repeat (20) @(negedge aclk);
		chk({33'h0, ser_en}, 34'h1);
		u_host.set_pins(1'b0, 1'b0, 1'b0);
		wait_for(2, 1'b0, 120);
		u_host.set_pins(1'b1, 1'b0, 1'b0);
		wait_for(0, 1'b0, INIT + 40);
		xfer(0, 8'h04, 0, 34'h1);
		wait_for(0, 1'b1, 10);
		$display("test pins done");
		// Unmapped and read-only places, then link frames
		xfer(0, 8'h10, 0, 34'h2_0000_0000);
		xfer(1, 8'h14, 32'hFFFF_FFFF, 34'h2_0000_0000);
		xfer(1, 8'h00, 32'hFFFF_FFFF, 34'h0);
		repeat (3) u_host.frame();
		xfer(0, 8'h00, 0, 34'h0_A000_0204);
		$display("test bus done");
		report_and_stop(0);
	end
endmodule : module_sideband_control_status_test

`default_nettype wire
